// File: src/link_hs_pkg.sv
// Shared constants, types and register map for the link startup handshake block.
package link_hs_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h00C;
  localparam logic [11:0] OFF_IRQ_EN = 12'h010;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int CTRL_FLAG_PAYLOAD = 0;
  localparam int CTRL_DIV_LO = 1;
  localparam int CTRL_DIV_HI = 2;
  localparam int CTRL_SOFT_RESET = 3;
  localparam int IRQ_LOCK_GAINED = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_PEER_READY = 2;
  localparam int IRQ_ERROR_PAIR = 3;
  localparam int IRQ_BITS = 4;
  // ****************************************************************
  // Frame kinds and timing
  // ****************************************************************
  localparam logic [1:0] KIND_FILL0 = 2'h0;
  localparam logic [1:0] KIND_FILL1 = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam logic [1:0] KIND_ERROR = 2'h3;
  localparam logic [7:0] CLEAN_FRAMES = 8'h80;
  localparam int SYNC_PINS = 6;
  typedef enum logic [1:0] {st_acquire, st_wait_peer, st_send_data} hs_state_t;
  typedef struct packed {
    logic [1:0] kind;
    logic flag;
  } rx_frame_t;
  typedef struct packed {
    logic send_payload;
    logic fill_one;
    logic flag;
  } tx_frame_t;
endpackage

// File: src/rate_tick_gen.sv
// Frame-rate enable divider selected by the two rate divider bits.
`timescale 1ns/100ps
`default_nettype none
module rate_tick_gen (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_div_sel,
  output logic o_tick
);
  logic [2:0] cnt;
  logic [2:0] last;

  always_comb begin
    case (i_div_sel)
      2'h0: last = 3'h0;
      2'h1: last = 3'h1;
      2'h2: last = 3'h3;
      default: last = 3'h7;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 3'h0;
    end else if (cnt >= last) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  assign o_tick = (cnt >= last);
endmodule // rate_tick_gen
`default_nettype wire

// File: src/flag_alternation.sv
// Transmit flag toggling and receive flag alternation check.
`timescale 1ns/100ps
`default_nettype none
module flag_alternation (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_check_on,
  input wire link_hs_pkg::rx_frame_t i_rx,
  output logic o_tx_flag,
  output logic o_flag_err
);
  logic expect_odd;

  // A data run must start even; any other frame restarts the pairing.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      expect_odd <= 1'b0;
    end else if (i_tick) begin
      if (i_rx.kind == link_hs_pkg::KIND_DATA) begin
        expect_odd <= !expect_odd;
      end else begin
        expect_odd <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_flag <= 1'b0;
    end else if (i_tick) begin
      o_tx_flag <= i_check_on ? !o_tx_flag : 1'b0;
    end
  end

  assign o_flag_err = i_check_on && i_tick && (i_rx.kind == link_hs_pkg::KIND_DATA) &&
                      (i_rx.flag != expect_odd);
endmodule // flag_alternation
`default_nettype wire

// File: src/serial_link_startup_handshake.sv
// Link startup handshake controller with APB registers and interrupt.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Transmit PLL lock releases handshake machine
// - Both status low: send fill zero; code sends fill_sel and permit pins, not status
// - Frame lock raises local lock outputs
// - Peer fill one raises peer ready
// - Payload permit retimed to host ready
// - Two errors or lost line drop lock
// - Frequency lock switches detector and input
// - Two errors return to reference hunt
// - Flag toggled and alternation checked
// - Change only after two matching frames
// - Hold initial state until 128 clean
// - Initial state disables interfaces, frequency mode
module serial_link_startup_handshake (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_handshake_reset_a_n,
  input wire logic i_handshake_reset_b_n,
  input wire logic i_tx_pll_locked,
  input wire logic i_fill_pattern_select,
  input wire logic i_tx_payload_permit,
  input wire logic i_rx_signal_lost,
  input wire link_hs_pkg::rx_frame_t i_rx_frame,
  output link_hs_pkg::tx_frame_t o_tx_frame,
  output logic o_tx_pll_lock,
  output logic o_host_send_ok,
  output logic o_local_lock_status,
  output logic o_peer_ready_status,
  output logic o_freq_detector_off,
  output logic o_rx_active,
  output logic o_rx_input_data,
  output logic o_frame_tick,
  output logic o_irq
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [link_hs_pkg::SYNC_PINS-1:0] pin_meta;
  logic [link_hs_pkg::SYNC_PINS-1:0] pin_sync;
  logic reset_a_ok;
  logic reset_b_ok;
  logic pll_locked;
  logic fill_sel;
  logic permit;
  logic line_lost;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {i_rx_signal_lost, i_tx_payload_permit, i_fill_pattern_select,
                   i_tx_pll_locked, i_handshake_reset_b_n, i_handshake_reset_a_n};
      pin_sync <= pin_meta;
    end
  end

  assign reset_a_ok = pin_sync[0];
  assign reset_b_ok = pin_sync[1];
  assign pll_locked = pin_sync[2];
  assign fill_sel = pin_sync[3];
  assign permit = pin_sync[4];
  assign line_lost = pin_sync[5];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [4:0] ctrl;
  logic [link_hs_pkg::IRQ_BITS-1:0] irq_stat;
  logic [link_hs_pkg::IRQ_BITS-1:0] irq_en;
  logic [link_hs_pkg::IRQ_BITS-1:0] irq_set;
  logic setup;
  logic wr_en;
  logic mapped;
  logic [31:0] next_rdata;
  link_hs_pkg::hs_state_t state;
  link_hs_pkg::hs_state_t next_state;

  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign o_pready = i_penable;
  assign mapped = (i_paddr == link_hs_pkg::OFF_CTRL) || (i_paddr == link_hs_pkg::OFF_STATUS) ||
                  (i_paddr == link_hs_pkg::OFF_IRQ_STAT) || (i_paddr == link_hs_pkg::OFF_IRQ_CLR) ||
                  (i_paddr == link_hs_pkg::OFF_IRQ_EN);
  assign o_pslverr = i_psel && i_penable && !mapped;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= link_hs_pkg::CTRL_RESET;
    end else if (wr_en && i_paddr == link_hs_pkg::OFF_CTRL) begin
      ctrl <= {1'b0, i_pwdata[3:0]};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en <= '0;
    end else if (wr_en && i_paddr == link_hs_pkg::OFF_IRQ_EN) begin
      irq_en <= i_pwdata[link_hs_pkg::IRQ_BITS-1:0];
    end
  end

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat <= '0;
    end else if (wr_en && i_paddr == link_hs_pkg::OFF_IRQ_CLR) begin
      irq_stat <= (irq_stat & ~i_pwdata[link_hs_pkg::IRQ_BITS-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  assign o_irq = |(irq_stat & irq_en);

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_paddr)
      link_hs_pkg::OFF_CTRL: next_rdata[4:0] = ctrl;
      link_hs_pkg::OFF_STATUS: next_rdata[6:0] = {line_lost, pll_locked, o_host_send_ok,
                                                  o_peer_ready_status, o_local_lock_status, state};
      link_hs_pkg::OFF_IRQ_STAT: next_rdata[link_hs_pkg::IRQ_BITS-1:0] = irq_stat;
      link_hs_pkg::OFF_IRQ_EN: next_rdata[link_hs_pkg::IRQ_BITS-1:0] = irq_en;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup && !i_pwrite) begin
      o_prdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Frame tick and flag handling
  // ****************************************************************
  logic tick;
  logic flag_err;
  logic tx_flag;

  rate_tick_gen u_tick (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_div_sel(ctrl[link_hs_pkg::CTRL_DIV_HI:link_hs_pkg::CTRL_DIV_LO]),
    .o_tick(tick)
  );

  flag_alternation u_flag (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_tick(tick),
    .i_check_on(!ctrl[link_hs_pkg::CTRL_FLAG_PAYLOAD]),
    .i_rx(i_rx_frame),
    .o_tx_flag(tx_flag),
    .o_flag_err(flag_err)
  );

  assign o_frame_tick = tick;

  // ****************************************************************
  // Handshake state machine
  // ****************************************************************
  logic hold;
  logic frame_err;
  logic err_prev;
  logic err_pair;
  logic [1:0] prev_kind;
  logic prev_valid;
  logic confirm;
  logic [7:0] clean_cnt;
  logic clean_done;

  // Without a locked transmitter the link is held in its initial state.
  assign hold = !reset_a_ok || !reset_b_ok || !pll_locked || ctrl[link_hs_pkg::CTRL_SOFT_RESET];
  assign frame_err = tick && ((i_rx_frame.kind == link_hs_pkg::KIND_ERROR) || flag_err);
  assign err_pair = frame_err && err_prev;
  assign confirm = tick && prev_valid && !frame_err && (i_rx_frame.kind == prev_kind);
  assign clean_done = (clean_cnt == link_hs_pkg::CLEAN_FRAMES);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_prev <= 1'b0;
      prev_kind <= link_hs_pkg::KIND_FILL0;
      prev_valid <= 1'b0;
    end else if (tick) begin
      err_prev <= frame_err;
      prev_kind <= i_rx_frame.kind;
      prev_valid <= !frame_err;
    end
  end

  // The clean-frame timer keeps bit slips during acquisition from faking lock.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clean_cnt <= 8'h00;
    end else if (hold || err_pair || line_lost) begin
      clean_cnt <= 8'h00;
    end else if (tick && frame_err) begin
      clean_cnt <= 8'h00;
    end else if (tick && !clean_done) begin
      clean_cnt <= clean_cnt + 8'h01;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      link_hs_pkg::st_acquire: begin
        if (clean_done && confirm && (i_rx_frame.kind == link_hs_pkg::KIND_FILL0 ||
            i_rx_frame.kind == link_hs_pkg::KIND_FILL1)) begin
          next_state = link_hs_pkg::st_wait_peer;
        end
      end
      link_hs_pkg::st_wait_peer: begin
        if (confirm && i_rx_frame.kind == link_hs_pkg::KIND_FILL1) begin
          next_state = link_hs_pkg::st_send_data;
        end
      end
      link_hs_pkg::st_send_data: begin
        if (confirm && i_rx_frame.kind == link_hs_pkg::KIND_FILL0) begin
          next_state = link_hs_pkg::st_acquire;
        end
      end
      default: next_state = link_hs_pkg::st_acquire;
    endcase
    if (hold || err_pair || line_lost) begin
      next_state = link_hs_pkg::st_acquire;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= link_hs_pkg::st_acquire;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Status outputs and transmitter control
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_local_lock_status <= 1'b0;
      o_peer_ready_status <= 1'b0;
    end else begin
      o_local_lock_status <= (next_state != link_hs_pkg::st_acquire);
      o_peer_ready_status <= (next_state == link_hs_pkg::st_send_data);
    end
  end

  // Detector off, receiver active and data input all follow local lock.
  assign o_freq_detector_off = o_local_lock_status;
  assign o_rx_active = o_local_lock_status;
  assign o_rx_input_data = o_local_lock_status;
  assign o_tx_pll_lock = pll_locked;

  // Permit is retimed to the frame tick so the host sees it on a frame boundary.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_host_send_ok <= 1'b0;
    end else if (tick) begin
      o_host_send_ok <= permit && pll_locked;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_frame <= '0;
    end else if (tick) begin
      o_tx_frame.send_payload <= permit && pll_locked;
      o_tx_frame.fill_one <= fill_sel;
      o_tx_frame.flag <= tx_flag;
    end
  end

  assign irq_set[link_hs_pkg::IRQ_LOCK_GAINED] = (state == link_hs_pkg::st_acquire) &&
                                                 (next_state != link_hs_pkg::st_acquire);
  assign irq_set[link_hs_pkg::IRQ_LOCK_LOST] = (state != link_hs_pkg::st_acquire) &&
                                               (next_state == link_hs_pkg::st_acquire);
  assign irq_set[link_hs_pkg::IRQ_PEER_READY] = (state != link_hs_pkg::st_send_data) &&
                                                (next_state == link_hs_pkg::st_send_data);
  assign irq_set[link_hs_pkg::IRQ_ERROR_PAIR] = err_pair;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_hold_forces_init:
    assert property (hold |=> state == link_hs_pkg::st_acquire ##1 !o_local_lock_status)
    else $error("hold did not force the initial state");
  a_fill_zero_idle:
    assert property (tick && !permit && !fill_sel |=> !o_tx_frame.send_payload && !o_tx_frame.fill_one)
    else $error("fill zero not sent while idle");
  a_lock_outputs:
    assert property (o_local_lock_status |-> o_freq_detector_off && o_rx_active && o_rx_input_data)
    else $error("lock did not steer receiver controls");
  a_peer_needs_lock:
    assert property ($rose(o_peer_ready_status) |-> $past(o_local_lock_status))
    else $error("peer ready raised without local lock");
  a_send_ok_retimed:
    assert property ($rose(o_host_send_ok) |-> $past(tick) && $past(permit))
    else $error("host ready not retimed from permit");
  a_error_pair_drop:
    assert property (err_pair |=> state == link_hs_pkg::st_acquire && clean_cnt == 8'h00)
    else $error("two errors did not drop lock");
  a_flag_toggles:
    assert property (tick && !ctrl[link_hs_pkg::CTRL_FLAG_PAYLOAD] |=> o_tx_frame.flag != tx_flag)
    else $error("transmit flag did not alternate");
  a_debounced_step:
    assert property ($rose(o_peer_ready_status) |-> $past(confirm))
    else $error("state changed without two matching frames");
  a_lock_needs_clean:
    assert property ($rose(o_local_lock_status) |-> $past(clean_done))
    else $error("lock left initial state before clean frames");
  a_init_disabled:
    assert property (state == link_hs_pkg::st_acquire |-> !o_peer_ready_status && !o_freq_detector_off)
    else $error("initial state left interfaces enabled");

  c_reach_lock: cover property ($rose(o_local_lock_status));
  c_reach_data: cover property ($rose(o_peer_ready_status));
  c_error_pair: cover property (err_pair && o_local_lock_status);
endmodule // serial_link_startup_handshake
`default_nettype wire

// File: tb/peer_model.sv
// Behavioural model of the remote transceiver pair that feeds received frames.
`timescale 1ns/100ps
`default_nettype none
module peer_model (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic [2:0] i_mode,
  output var link_hs_pkg::rx_frame_t o_frame
);
  logic flag;
  // Mode 2 sends data whose flag alternates from 0; mode 4 sends the inverse order on purpose.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag <= 1'b0;
    end else if (i_mode < 3'h2) begin
      flag <= 1'b0;
    end else if (i_tick && (i_mode == 3'h2 || i_mode == 3'h4)) begin
      flag <= ~flag;
    end
  end
  always_comb begin
    case (i_mode)
      3'h0: o_frame = '{kind: link_hs_pkg::KIND_FILL0, flag: 1'b0};
      3'h1: o_frame = '{kind: link_hs_pkg::KIND_FILL1, flag: 1'b0};
      3'h2: o_frame = '{kind: link_hs_pkg::KIND_DATA, flag: flag};
      3'h4: o_frame = '{kind: link_hs_pkg::KIND_DATA, flag: ~flag};
      default: o_frame = '{kind: link_hs_pkg::KIND_ERROR, flag: 1'b0};
    endcase
  end
endmodule // peer_model
`default_nettype wire

// File: tb/serial_link_startup_handshake_tb.sv
// Self-checking bench for the link startup handshake controller.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; $display("BAD %s exp %h got %h", nm, ex, got); end end
`define WAITFOR(cond, lim) begin for (int k = 0; k < lim && !(cond); k++) begin @(posedge i_mclk); #1; end end
module serial_link_startup_handshake_tb;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  logic i_mclk, i_rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic hs_a_n, hs_b_n, pll, sig_lost, tx_pll_lock, send_ok, lock, peer_ok, fd_off, rx_act, rx_in, tick, irq;
  logic sync_on, sync_pulse, fill_pin, permit_pin;
  logic [2:0] mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  link_hs_pkg::rx_frame_t rx_frame;
  link_hs_pkg::tx_frame_t tx_frame;
  int err_total, n_compared, cyc, nt;
  row_t rows[9] = '{
    '{link_hs_pkg::OFF_CTRL, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{link_hs_pkg::OFF_IRQ_EN, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{link_hs_pkg::OFF_CTRL, 1'b1, 32'hFFFF_FFF7, 32'h0000_0007, 1'b0},
    '{link_hs_pkg::OFF_IRQ_EN, 1'b1, 32'hFFFF_FFFF, 32'h0000_000F, 1'b0},
    '{link_hs_pkg::OFF_IRQ_EN, 1'b1, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{link_hs_pkg::OFF_STATUS, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
    '{link_hs_pkg::OFF_IRQ_STAT, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
    '{12'h014, 1'b1, 32'h1234_5678, 32'h0000_0000, 1'b1},
    '{link_hs_pkg::OFF_CTRL, 1'b1, 32'h0000_0000, 32'h0000_0000, 1'b0}};

  serial_link_startup_handshake u_serial_link_startup_handshake (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_handshake_reset_a_n(hs_a_n),
    .i_handshake_reset_b_n(hs_b_n), .i_tx_pll_locked(pll), .i_fill_pattern_select(fill_pin),
    .i_tx_payload_permit(permit_pin), .i_rx_signal_lost(sig_lost), .i_rx_frame(rx_frame),
    .o_tx_frame(tx_frame), .o_tx_pll_lock(tx_pll_lock), .o_host_send_ok(send_ok),
    .o_local_lock_status(lock), .o_peer_ready_status(peer_ok), .o_freq_detector_off(fd_off),
    .o_rx_active(rx_act), .o_rx_input_data(rx_in), .o_frame_tick(tick), .o_irq(irq));
  // The model hands over decoded frames, whichever serial input the board routes the stream to.
  peer_model u_peer_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tick(tick), .i_mode(mode),
    .o_frame(rx_frame));
  // In the periodic-sync scheme fill select is held high and a low pulse on permit forces fill one.
  assign fill_pin = sync_on || lock;
  assign permit_pin = sync_on ? !sync_pulse : peer_ok;

  // ****************************************************************
  // Clock, timeout and shared tasks
  // ****************************************************************
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // A single fill-one frame must not move the machine; a pair must.
  task automatic relock();
    @(posedge i_mclk) mode <= 3'h0;
    `WAITFOR(lock, 200)
    `CHK("lock", 1'b1, lock)
    `CHK("fd rx ", {3{1'b1}}, {fd_off, rx_act, rx_in})
    repeat (4) @(posedge i_mclk);
    #1 `CHK("fill one", 1'b1, tx_frame.fill_one)
    @(posedge i_mclk) mode <= 3'h1;
    @(posedge i_mclk) mode <= 3'h0;
    repeat (4) @(posedge i_mclk);
    #1 `CHK("peer one", 1'b0, peer_ok)
    @(posedge i_mclk) mode <= 3'h1;
    `WAITFOR(peer_ok, 10)
    `CHK("peer", 1'b1, peer_ok)
    `WAITFOR(send_ok, 8)
    `CHK("send ok", 1'b1, send_ok)
    `CHK("payload", 1'b1, tx_frame.send_payload)
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {i_rst_n, psel, penable, pwrite, pll, sig_lost, paddr, pwdata, mode, sync_on, sync_pulse} = '0;
    {hs_a_n, hs_b_n} = 2'b11;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (rows[i].w) apb(rows[i].a, 1'b0, 32'h0000_0000);
      `CHK("rdata", rows[i].q, q)
      `CHK("slverr", rows[i].e, e)
    end
    repeat (140) @(posedge i_mclk);
    #1 `CHK("lock pll low", 1'b0, lock)
    @(posedge i_mclk) pll <= 1'b1;
    repeat (3) @(posedge i_mclk);
    #1 `CHK("pll lock", 1'b1, tx_pll_lock)
    `CHK("fill zero", 2'b00, {tx_frame.fill_one, tx_frame.send_payload})
    `CHK("fd off", 1'b0, fd_off)
    repeat (100) @(posedge i_mclk);
    #1 `CHK("lock early", 1'b0, lock)
    relock();
    apb(link_hs_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
    `CHK("status", 32'h0000_003E, q)
    apb(link_hs_pkg::OFF_IRQ_STAT, 1'b0, 32'h0000_0000);
    `CHK("irq stat", 32'h0000_0005, q)
    `CHK("irq masked", 1'b0, irq)
    apb(link_hs_pkg::OFF_IRQ_EN, 1'b1, 32'h0000_0004);
    `CHK("irq on", 1'b1, irq)
    apb(link_hs_pkg::OFF_IRQ_CLR, 1'b1, 32'h0000_0004);
    `CHK("irq clr", 1'b0, irq)
    apb(link_hs_pkg::OFF_IRQ_EN, 1'b1, 32'h0000_0002);
    @(posedge i_mclk) mode <= 3'h3;
    @(posedge i_mclk) mode <= 3'h1;
    repeat (6) @(posedge i_mclk);
    #1 `CHK("one error", 1'b1, lock & peer_ok)
    @(posedge i_mclk) mode <= 3'h2;
    repeat (20) @(posedge i_mclk);
    #1 `CHK("data lock", 1'b1, lock)
    @(posedge i_mclk) mode <= 3'h3;
    repeat (2) @(posedge i_mclk);
    mode <= 3'h1;
    `WAITFOR(!lock, 8)
    `CHK("two errors", 2'b00, {lock, peer_ok})
    `CHK("irq lost", 1'b1, irq)
    repeat (100) @(posedge i_mclk);
    #1 `CHK("hold off", 1'b0, lock)
    for (int j = 0; j < 5; j++) begin
      relock();
      @(posedge i_mclk);
      case (j)
        0: mode <= 3'h4;
        1: sig_lost <= 1'b1;
        2: hs_a_n <= 1'b0;
        3: hs_b_n <= 1'b0;
        default: apb(link_hs_pkg::OFF_CTRL, 1'b1, 32'h0000_0008);
      endcase
      `WAITFOR(!lock, 12)
      `CHK("drop", 1'b0, lock)
      repeat (6) @(posedge i_mclk);
      #1 `CHK("send off", 1'b0, send_ok)
      @(posedge i_mclk) {sig_lost, hs_a_n, hs_b_n} <= 3'b011;
      if (j == 4) apb(link_hs_pkg::OFF_CTRL, 1'b1, 32'h0000_0000);
    end
    // The sync pulse is held until lock is seen, so it outlasts the clean-frame hold; lock comes from the fill-one frames.
    @(posedge i_mclk) {sync_on, sync_pulse, mode} <= {2'b11, 3'h1};
    repeat (4) @(posedge i_mclk);
    #1 `CHK("sync fill", 3'b100, {tx_frame.fill_one, tx_frame.send_payload, send_ok})
    `WAITFOR(lock, 200)
    `CHK("sync lock", 1'b1, lock)
    @(posedge i_mclk) sync_pulse <= 1'b0;
    repeat (4) @(posedge i_mclk);
    #1 `CHK("sync data", 2'b11, {tx_frame.send_payload, send_ok})
    @(posedge i_mclk) sync_on <= 1'b0;
    @(posedge i_mclk);
    #1 e = tx_frame.flag;
    @(posedge i_mclk);
    #1 `CHK("tx flag", ~e, tx_frame.flag)
    apb(link_hs_pkg::OFF_CTRL, 1'b1, 32'h0000_0006);
    nt = 0;
    repeat (64) begin
      @(posedge i_mclk);
      #1 nt += int'(tick);
    end
    `CHK("ticks", 8, nt)
    @(posedge i_mclk) i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 `CHK("reset", 5'b00000, {lock, peer_ok, irq, send_ok, tx_pll_lock})
    finish_test();
  end
endmodule // serial_link_startup_handshake_tb
`default_nettype wire
